// file: rtl/sdr_consts.svh
// constants of the sdram read path: timing, command codes, register map
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH

`define SDR_CLK_PERIOD_PS      8000
`define SDR_ACT_TO_ACCESS_NS   20
`define SDR_ACT_TO_ACCESS_CYC  ((`SDR_ACT_TO_ACCESS_NS * 1000 + `SDR_CLK_PERIOD_PS - 1) / `SDR_CLK_PERIOD_PS)

`define SDR_CMD_ACT            4'h3
`define SDR_CMD_READ           4'h5
`define SDR_CMD_WRITE          4'h4
`define SDR_CMD_PRE            4'h2
`define SDR_CMD_BST            4'h6
`define SDR_AP_BIT             10

`define SDR_REG_CONFIG         12'h000
`define SDR_REG_STATUS         12'h004
`define SDR_REG_ROW_BASE       8'h01
`define SDR_CFG_CL_LSB         0
`define SDR_CFG_BL_LSB         4
`define SDR_CFG_CL_RESET       2'h2
`define SDR_CFG_BL_RESET       3'h2
`define SDR_BL_FULL            3'h7
`define SDR_ST_OPEN_LSB        0
`define SDR_ST_BUSY_BIT        4
`define SDR_ST_DRIVE_BIT       5
`define SDR_ST_ERR_LSB         8

`endif

// file: rtl/sdr_pkg.sv
// types shared by the sdram read path
package sdr_pkg;

    typedef enum logic [2:0] {
        cmd_none,
        cmd_act,
        cmd_read,
        cmd_write,
        cmd_pre,
        cmd_bst
    } sdr_cmd_type;

    typedef enum logic {
        burst_idle,
        burst_run
    } sdr_burst_state_type;

endpackage : sdr_pkg

// file: rtl/sdr_bank_track.sv
// one bank: open flag, open row and age since activation
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"
module sdr_bank_track #(
    parameter int ROW_W   = 12,
    parameter int CNT_W   = 4,
    parameter int ACT_CYC = `SDR_ACT_TO_ACCESS_CYC
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // commands for this bank
    input  wire logic             act,
    input  wire logic             pre,
    input  wire logic [ROW_W-1:0] row_in,
    // bank state
    output logic                  is_open,
    output logic      [ROW_W-1:0] open_row,
    output logic                  access_ready
);

    logic [CNT_W-1:0] age;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            is_open  <= 1'b0;
            open_row <= '0;
        end else if (clk_en) begin
            // activation wins: a same-cycle close and reopen leaves the new row open
            if (act) begin
                is_open  <= 1'b1;
                open_row <= row_in;
            end else if (pre) begin
                is_open  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            age <= '0;
        end else if (clk_en) begin
            if (act) begin
                age <= CNT_W'(1);
            end else if (is_open && age != {CNT_W{1'b1}}) begin
                age <= age + CNT_W'(1);
            end
        end
    end

    assign access_ready = is_open && (age >= CNT_W'(ACT_CYC));

endmodule : sdr_bank_track
`default_nettype wire

// file: rtl/sdr_read_path.sv
// sdram device side: bank activation, read bursts, truncation, output masking, apb registers
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"
module sdr_read_path
    import sdr_pkg::*;
#(
    parameter int DQ_W         = 16,
    parameter int COL_W        = 8,
    parameter int ROW_W        = 12,
    parameter int MEM_ROW_BITS = 1
) (
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // memory pins
    input  wire logic             cs_n,
    input  wire logic             ras_n,
    input  wire logic             cas_n,
    input  wire logic             we_n,
    input  wire logic [1:0]       bank_select_lines,
    input  wire logic [ROW_W-1:0] addr,
    input  wire logic             dqm,
    input  wire logic [DQ_W-1:0]  dq_in,
    output logic      [DQ_W-1:0]  dq_out,
    output logic                  dq_oe
);

    localparam int PIN_W = 7 + ROW_W + DQ_W;
    localparam int AW    = 2 + MEM_ROW_BITS + COL_W;

    // pin synchronisers
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [3:0]       cmd_pins;
    logic             cmd_dqm;
    logic [1:0]       cmd_bank;
    logic [ROW_W-1:0] cmd_row;
    logic [DQ_W-1:0]  cmd_dq;
    logic [COL_W-1:0] cmd_col;
    sdr_cmd_type      cmd;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= {1'b1, {(PIN_W-1){1'b0}}};
            pin_s2 <= {1'b1, {(PIN_W-1){1'b0}}};
        end else if (clk_en) begin
            pin_s1 <= {cs_n, ras_n, cas_n, we_n, dqm, bank_select_lines, addr, dq_in};
            pin_s2 <= pin_s1;
        end
    end

    assign {cmd_pins, cmd_dqm, cmd_bank, cmd_row, cmd_dq} = pin_s2;
    assign cmd_col = cmd_row[COL_W-1:0];

    always_comb begin
        case (cmd_pins)
            `SDR_CMD_ACT:   cmd = cmd_act;
            `SDR_CMD_READ:  cmd = cmd_read;
            `SDR_CMD_WRITE: cmd = cmd_write;
            `SDR_CMD_PRE:   cmd = cmd_pre;
            `SDR_CMD_BST:   cmd = cmd_bst;
            default:        cmd = cmd_none;
        endcase
    end

    // configuration and sticky errors
    logic [1:0]       cfg_cl;
    logic [2:0]       cfg_bl;
    logic [2:0]       err;
    logic [1:0]       cl_eff;
    logic             bl_full;
    logic [3:0]       bl_len;
    logic [COL_W-1:0] bl_mask;

    // a latency of zero makes no sense here; run it as one
    assign cl_eff  = (cfg_cl == 2'h0) ? 2'h1 : cfg_cl;
    assign bl_full = (cfg_bl == `SDR_BL_FULL);
    assign bl_len  = 4'h1 << cfg_bl[1:0];
    assign bl_mask = bl_full ? {COL_W{1'b1}} : COL_W'(bl_len - 4'h1);

    // bank tracking
    logic [3:0]       bank_open;
    logic [3:0]       bank_ready;
    logic [3:0]       act_b;
    logic [3:0]       pre_b;
    logic [ROW_W-1:0] open_row [4];
    logic             ap_fire;
    logic [1:0]       ap_bank;

    for (genvar b = 0; b < 4; b++) begin : g_bank
        assign act_b[b] = (cmd == cmd_act) && (cmd_bank == 2'(b));
        assign pre_b[b] = ((cmd == cmd_pre) && (cmd_row[`SDR_AP_BIT] || cmd_bank == 2'(b)))
                          || (ap_fire && ap_bank == 2'(b));
        sdr_bank_track #(
            .ROW_W        (ROW_W)
        ) u_bank (
            .clk          (clk),
            .rst_n        (rst_n),
            .clk_en       (clk_en),
            .act          (act_b[b]),
            .pre          (pre_b[b]),
            .row_in       (cmd_row),
            .is_open      (bank_open[b]),
            .open_row     (open_row[b]),
            .access_ready (bank_ready[b])
        );
    end

    // command acceptance
    logic read_ok;
    logic cmd_ap;
    logic wr_ok;
    logic wr_invalid;
    logic stop_cmd;
    logic read_pending;
    logic dqm_d1;
    logic pipe0_v;
    logic pipe1_v;

    assign read_ok  = (cmd == cmd_read) && bank_open[cmd_bank];
    assign cmd_ap   = cmd_row[`SDR_AP_BIT] && !bl_full;
    assign wr_ok    = (cmd == cmd_write) && bank_open[cmd_bank];

    // burst engine
    sdr_burst_state_type burst_state;
    logic [1:0]          burst_bank;
    logic [COL_W-1:0]    burst_col;
    logic [COL_W-1:0]    burst_mask;
    logic [3:0]          burst_left;
    logic                burst_ap;
    logic                burst_full;
    logic                launch_valid;
    logic [1:0]          launch_bank;
    logic [COL_W-1:0]    launch_col;
    logic [3:0]          launch_left;
    logic                launch_ap;
    logic                launch_full;
    logic                last_launch;

    assign stop_cmd = (cmd == cmd_bst) || (cmd == cmd_write)
                      || ((cmd == cmd_pre) && (cmd_row[`SDR_AP_BIT] || cmd_bank == burst_bank));

    function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] col, input logic [COL_W-1:0] mask);
        // wraps inside the aligned burst; an all-ones mask wraps at the page end
        next_col = (col & ~mask) | ((col + COL_W'(1)) & mask);
    endfunction : next_col

    always_comb begin
        launch_valid = 1'b0;
        launch_bank  = burst_bank;
        launch_col   = burst_col;
        launch_left  = burst_left;
        launch_ap    = burst_ap;
        launch_full  = burst_full;
        if (read_ok) begin
            launch_valid = 1'b1;
            launch_bank  = cmd_bank;
            launch_col   = cmd_col;
            launch_left  = bl_len;
            launch_ap    = cmd_ap;
            launch_full  = bl_full;
        end else if (burst_state == burst_run && !stop_cmd) begin
            launch_valid = 1'b1;
        end
    end

    assign last_launch = launch_valid && !launch_full && (launch_left == 4'h1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_state <= burst_idle;
            burst_bank  <= 2'h0;
            burst_col   <= '0;
            burst_mask  <= '0;
            burst_left  <= 4'h0;
            burst_ap    <= 1'b0;
            burst_full  <= 1'b0;
        end else if (clk_en) begin
            if (read_ok) begin
                burst_bank  <= cmd_bank;
                burst_col   <= next_col(cmd_col, bl_mask);
                burst_mask  <= bl_mask;
                burst_left  <= bl_len - 4'h1;
                burst_ap    <= cmd_ap;
                burst_full  <= bl_full;
                burst_state <= last_launch ? burst_idle : burst_run;
            end else if (burst_state == burst_run) begin
                if (stop_cmd || last_launch) begin
                    burst_state <= burst_idle;
                end else begin
                    burst_col  <= next_col(burst_col, burst_mask);
                    burst_left <= burst_left - 4'h1;
                end
            end
        end
    end

    // auto precharge closes the bank the cycle after the last launch,
    // the same moment an optimally placed explicit precharge would act
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ap_fire <= 1'b0;
            ap_bank <= 2'h0;
        end else if (clk_en) begin
            ap_fire <= last_launch && launch_ap;
            ap_bank <= launch_bank;
        end
    end

    // storage, flip-flops indexed by bank, low row bits and column
    logic [DQ_W-1:0] mem [2**AW];
    logic [DQ_W-1:0] launch_data;

    function automatic logic [AW-1:0] mem_idx(input logic [1:0] bank, input logic [ROW_W-1:0] row,
                                              input logic [COL_W-1:0] col);
        mem_idx = {bank, row[MEM_ROW_BITS-1:0], col};
    endfunction : mem_idx

    assign launch_data  = mem[mem_idx(launch_bank, open_row[launch_bank], launch_col)];
    assign read_pending = (burst_state == burst_run) || pipe0_v || pipe1_v;
    assign wr_invalid   = wr_ok && read_pending && !dqm_d1;

    // single-element store of the data coincident with WRITE, masked with zero latency
    always_ff @(posedge clk) begin
        if (clk_en && wr_ok && !wr_invalid && !cmd_dqm) begin
            mem[mem_idx(cmd_bank, open_row[cmd_bank], cmd_col)] <= cmd_dq;
        end
    end

    // output pipeline
    logic [DQ_W-1:0] pipe0_d;
    logic [DQ_W-1:0] pipe1_d;
    logic            sel_v;
    logic [DQ_W-1:0] sel_d;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pipe0_v <= 1'b0;
            pipe1_v <= 1'b0;
            pipe0_d <= '0;
            pipe1_d <= '0;
            dqm_d1  <= 1'b0;
        end else if (clk_en) begin
            // a registered write discards all read data still in flight
            pipe0_v <= launch_valid && (cmd != cmd_write);
            pipe1_v <= pipe0_v && (cmd != cmd_write);
            pipe0_d <= launch_data;
            pipe1_d <= pipe0_d;
            dqm_d1  <= cmd_dqm;
        end
    end

    always_comb begin
        case (cl_eff)
            2'h1: begin
                sel_v = launch_valid;
                sel_d = launch_data;
            end
            2'h2: begin
                sel_v = pipe0_v;
                sel_d = pipe0_d;
            end
            default: begin
                sel_v = pipe1_v;
                sel_d = pipe1_d;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= '0;
            dq_oe  <= 1'b0;
        end else if (clk_en) begin
            dq_out <= sel_d;
            dq_oe  <= sel_v && !dqm_d1 && (cmd != cmd_write);
        end
    end

    // apb slave: zero wait states, read data latched in the setup cycle
    logic        apb_setup;
    logic        apb_access;
    logic        addr_hit;
    logic [31:0] status_word;
    logic [2:0]  err_set;
    logic [2:0]  err_clr;

    assign apb_setup   = psel && !penable;
    assign apb_access  = psel && penable;
    assign addr_hit    = (paddr == `SDR_REG_CONFIG) || (paddr == `SDR_REG_STATUS)
                         || (paddr[11:4] == `SDR_REG_ROW_BASE && paddr[1:0] == 2'h0);
    assign pready      = clk_en;
    assign pslverr     = apb_access && !addr_hit;
    assign status_word = (32'(bank_open) << `SDR_ST_OPEN_LSB)
                         | (32'(burst_state == burst_run) << `SDR_ST_BUSY_BIT)
                         | (32'(dq_oe) << `SDR_ST_DRIVE_BIT)
                         | (32'(err) << `SDR_ST_ERR_LSB);

    assign err_set = {wr_invalid,
                      (read_ok || wr_ok) && !bank_ready[cmd_bank],
                      ((cmd == cmd_read) || (cmd == cmd_write)) && !bank_open[cmd_bank]};
    assign err_clr = (apb_access && pwrite && paddr == `SDR_REG_STATUS)
                     ? pwdata[`SDR_ST_ERR_LSB +: 3] : 3'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_cl <= `SDR_CFG_CL_RESET;
            cfg_bl <= `SDR_CFG_BL_RESET;
            err    <= 3'h0;
        end else if (clk_en) begin
            if (apb_access && pwrite && paddr == `SDR_REG_CONFIG) begin
                cfg_cl <= pwdata[`SDR_CFG_CL_LSB +: 2];
                cfg_bl <= pwdata[`SDR_CFG_BL_LSB +: 3];
            end
            // a new event outranks a clear in the same cycle
            err <= (err & ~err_clr) | err_set;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (clk_en && apb_setup) begin
            if (paddr == `SDR_REG_CONFIG) begin
                prdata <= (32'(cfg_cl) << `SDR_CFG_CL_LSB) | (32'(cfg_bl) << `SDR_CFG_BL_LSB);
            end else if (paddr == `SDR_REG_STATUS) begin
                prdata <= status_word;
            end else if (addr_hit) begin
                prdata <= 32'(open_row[paddr[3:2]]);
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // checks, valid while clk_en stays high
    first_data_cl2_a: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        (launch_valid && cl_eff == 2'h2 && cmd != cmd_write) ##1 (!dqm_d1 && cmd != cmd_write)
        |=> (dq_oe && dq_out == $past(launch_data, 2)))
        else $error("read data not presented two clocks after launch");

    mask_blanks_a: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        cmd_dqm |-> ##2 !dq_oe)
        else $error("data driven two clocks after mask high");

    idle_float_a: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        (!launch_valid && !pipe0_v && !pipe1_v) |=> !dq_oe)
        else $error("data lines driven with no data pending");

    write_float_a: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        (cmd == cmd_write) |=> (!dq_oe && !pipe0_v))
        else $error("outputs or pipeline alive after write");

    page_wrap_a: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        (launch_valid && launch_full && launch_col == {COL_W{1'b1}})
        |=> (burst_col == '0 && burst_state == burst_run))
        else $error("full page burst did not wrap to column zero");

    auto_pre_fire_a: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        (last_launch && launch_ap) |=> (ap_fire && ap_bank == $past(launch_bank)))
        else $error("auto precharge not scheduled after last element");

    auto_pre_close_a: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        (ap_fire && !act_b[ap_bank]) |=> !bank_open[$past(ap_bank)])
        else $error("bank still open after auto precharge");

    terminate_stop_a: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        (cmd == cmd_bst && burst_state == burst_run && !read_ok)
        |-> (!launch_valid ##1 (burst_state == burst_idle && $stable(bank_open))))
        else $error("burst terminate did not stop burst or changed banks");

    gapless_chain_a: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        (read_ok && !bl_full && bl_len != 4'h1) ##1 (!stop_cmd && !read_ok)
        |-> (launch_valid && launch_col == next_col($past(cmd_col), $past(bl_mask))))
        else $error("gap or wrong column after read");

    other_bank_act_a: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        (cmd == cmd_act && burst_state == burst_run && cmd_bank != burst_bank)
        |-> launch_valid ##1 bank_open[$past(cmd_bank)])
        else $error("activate to other bank disturbed burst");

endmodule : sdr_read_path
`default_nettype wire

// file: tb/sdr_ctl_model.sv
// controller-side model driving the command, mask and write data pins
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"
module sdr_ctl_model #(
    parameter int GAP = 4
) (
    // clock
    input  wire logic        clk,
    // command, bank, address, mask and data pins
    output logic      [3:0]  cmd,
    output logic      [1:0]  bank,
    output logic      [11:0] addr,
    output logic             dqm,
    output logic      [15:0] dq
);
    initial begin
        cmd = 4'hf;
        bank = 2'h0;
        addr = 12'h0;
        dqm = 1'b0;
        dq = 16'h0;
    end
    task automatic drive(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a, input logic m,
                         input logic [15:0] d);
        @(posedge clk);
        cmd <= c;
        bank <= b;
        addr <= a;
        dqm <= m;
        // released lines flip rather than hold a stale value
        dq <= (c == `SDR_CMD_WRITE) ? d : ~dq;
    endtask : drive
    // gap covers activate-to-access, both activate intervals and precharge
    task automatic open_row(input logic [1:0] b, input logic [11:0] r);
        drive(`SDR_CMD_ACT, b, r, 1'b0, 16'h0);
        repeat (GAP) drive(4'h7, b, r, 1'b0, 16'h0);
    endtask : open_row
endmodule : sdr_ctl_model
`default_nettype wire

// file: tb/sdr_read_path_tb.sv
// self-checking bench for the sdram read path
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"
`define CHK(s, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", s, e, g); end end
module sdr_read_path_tb;
    localparam logic [3:0] c_nop = 4'h7;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, dqm, dq_oe, er, en;
    logic [11:0] paddr, addr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  cmd;
    logic [1:0]  bank;
    logic [15:0] dq_in, dq_out;
    logic [15:0] dq_v [32];
    logic        oe_v [32];
    int          miscompares = 0, check_count = 0, cycles = 0, n = 0;

    sdr_ctl_model i_ctl (.clk(clk), .cmd(cmd), .bank(bank), .addr(addr), .dqm(dqm), .dq(dq_in));
    sdr_read_path i_dut (.clk(clk), .rst_n(rst_n), .clk_en(en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
        .bank_select_lines(bank), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic status;
        apb(1'b0, `SDR_REG_STATUS, 32'h0);
    endtask : status
    task automatic cfg(input logic [1:0] cl, input logic [2:0] bl);
        apb(1'b1, `SDR_REG_CONFIG, {25'h0, bl, 2'h0, cl});
    endtask : cfg
    // one pin cycle, then capture the settled outputs
    task automatic step(input logic [3:0] c, input logic [11:0] a, input logic m, input logic [15:0] d);
        i_ctl.drive(c, 2'h0, a, m, d);
        #1;
        oe_v[n] = dq_oe;
        dq_v[n] = dq_out;
        n++;
    endtask : step
    task automatic nop;
        step(c_nop, 12'h0, 1'b0, 16'h0);
    endtask : nop
    task automatic rdc(input logic [11:0] a);
        step(`SDR_CMD_READ, a, 1'b0, 16'h0);
    endtask : rdc
    // column c holds 0x1000 plus c mod 4
    task automatic trace(input int first, input int cnt, input int col);
        repeat (8) nop();
        for (int i = 0; i < n; i++) begin
            `CHK("dq_oe", i >= first && i < first + cnt, oe_v[i])
            if (i >= first && i < first + cnt) `CHK("dq_out", 16'(16'h1000 + (col + i - first) % 4), dq_v[i])
        end
        n = 0;
    endtask : trace
    task automatic t_regs;
        // a frozen block must hold the bus off
        @(posedge clk);
        en <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("pready frozen", 1'b0, pready)
        @(posedge clk);
        en <= 1'b1;
        apb(1'b0, `SDR_REG_CONFIG, 32'h0);
        `CHK("config", 32'h22, rd)
        apb(1'b1, 12'h0f0, 32'h1);
        `CHK("pslverr", 1'b1, er)
        i_ctl.open_row(2'h0, 12'h005);
        apb(1'b0, 12'h010, 32'h0);
        `CHK("open row", 32'h5, rd)
        for (int i = 0; i < 5; i++) i_ctl.drive(`SDR_CMD_WRITE, 2'h0, i == 4 ? 12'h0ff : 12'(i), 1'b0,
                                                16'(16'h1000 + (i == 4 ? 3 : i)));
        i_ctl.drive(c_nop, 2'h0, 12'h0, 1'b0, 16'h0);
        $display("registers done");
    endtask : t_regs
    task automatic t_bursts;
        for (int cl = 1; cl <= 3; cl++) begin
            cfg(2'(cl), 3'h2);
            rdc(12'h002);
            trace(cl + 2, 4, 2);
        end
        $display("latency sweep done");
    endtask : t_bursts
    task automatic t_stops;
        cfg(2'h2, 3'h2);
        rdc(12'h000);
        rdc(12'h001);
        trace(4, 5, 0);
        rdc(12'h001);
        nop();
        step(`SDR_CMD_BST, 12'h0, 1'b0, 16'h0);
        trace(4, 2, 1);
        status();
        `CHK("row kept", 1'b1, rd[0])
        rdc(12'h001);
        nop();
        step(`SDR_CMD_PRE, 12'h0, 1'b0, 16'h0);
        trace(4, 2, 1);
        status();
        `CHK("row closed", 1'b0, rd[0])
        i_ctl.open_row(2'h0, 12'h005);
        rdc(12'h403);
        trace(4, 4, 3);
        status();
        `CHK("auto closed", 1'b0, rd[0])
        i_ctl.open_row(2'h0, 12'h005);
        cfg(2'h2, 3'h7);
        rdc(12'h0ff);
        nop();
        step(`SDR_CMD_BST, 12'h0, 1'b0, 16'h0);
        trace(4, 2, 3);
        $display("truncation done");
    endtask : t_stops
    task automatic t_turn;
        cfg(2'h2, 3'h2);
        rdc(12'h000);
        step(c_nop, 12'h0, 1'b1, 16'h0);
        step(c_nop, 12'h0, 1'b1, 16'h0);
        step(`SDR_CMD_WRITE, 12'h0, 1'b0, 16'h1000);
        trace(4, 1, 0);
        status();
        `CHK("valid write", 1'b0, rd[10])
        rdc(12'h000);
        step(`SDR_CMD_WRITE, 12'h0, 1'b0, 16'h0bad);
        repeat (6) nop();
        status();
        `CHK("invalid write", 1'b1, rd[10])
        apb(1'b1, `SDR_REG_STATUS, 32'h700);
        i_ctl.drive(`SDR_CMD_READ, 2'h3, 12'h0, 1'b0, 16'h0);
        repeat (4) nop();
        status();
        `CHK("idle access", 3'h1, rd[10:8])
        rdc(12'h000);
        i_ctl.open_row(2'h1, 12'h007);
        status();
        `CHK("other bank", 4'h3, rd[3:0])
        i_ctl.drive(`SDR_CMD_ACT, 2'h2, 12'h007, 1'b0, 16'h0);
        i_ctl.drive(`SDR_CMD_WRITE, 2'h2, 12'h000, 1'b0, 16'h0);
        repeat (4) nop();
        status();
        `CHK("early access", 3'h3, rd[10:8])
        n = 0;
        $display("turnaround done");
    endtask : t_turn
    initial begin
        rst_n = 1'b0;
        en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_bursts();
        t_stops();
        t_turn();
        test_done();
    end
endmodule : sdr_read_path_tb
`default_nettype wire
